// File: pkg/spd_defines.svh
// Constants of the serial program download port
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// Instruction opcodes (first byte of each four-byte instruction)
`define SPD_OP_ENABLE 8'ha1
`define SPD_OP_ERASE 8'ha2
`define SPD_OP_RD_PH 8'h10
`define SPD_OP_RD_PL 8'h11
`define SPD_OP_WR_PH 8'h20
`define SPD_OP_WR_PL 8'h21
`define SPD_OP_RD_EE 8'h30
`define SPD_OP_WR_EE 8'h31

// Second byte of the enable instruction, echoed while in step
`define SPD_SYNC_BYTE 8'h53
`define SPD_ERASED_BYTE 8'hff
`define SPD_FILL_BYTE 8'h00

// Address spaces: program words 0x000..0xfff, data bytes 0x000..0x1ff
`define SPD_PROG_WORDS 4096
`define SPD_EE_BYTES 512

// Host timing at 125 MHz
`define SPD_CLK_MHZ 125
`define SPD_T_WAIT_MS 20
`define SPD_WAIT_CYC (`SPD_T_WAIT_MS * `SPD_CLK_MHZ * 1000)
`define SPD_RST_PULSE_XTAL 2
`define SPD_SCK_MIN_XTAL 2
`define SPD_SCK_HALF_CYC 8

`endif

// File: pkg/spd_pkg.sv
// Types shared by both ends of the serial program download port
`default_nettype none
package spd_pkg;
  typedef logic [7:0] spd_byte_t;
  typedef logic [31:0] spd_instr_t;
  typedef enum {HS_PULSE, HS_WAIT, HS_SHIFT, HS_PUSH, HS_IDLE} spd_host_state_e;
endpackage
`default_nettype wire

// File: pkg/spd_if.sv
// Serial programming pins between programmer and device
`default_nettype none
interface spd_if;
  logic prog_rst_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport host (
    output prog_rst_n,
    output sck,
    output mosi,
    input miso,
    input miso_oe
  );
  modport dev (
    input prog_rst_n,
    input sck,
    input mosi,
    output miso,
    output miso_oe
  );
endinterface
`default_nettype wire

// File: rtl/spd_buf.sv
// Shift-style FIFO with valid and ready on both sides
`default_nettype none
module spd_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] data_reg [DEPTH];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic valid_reg;

  wire push = i_in_valid && o_in_ready;
  wire pop = valid_reg && i_out_ready;
  wire [CW-1:0] wr_idx = count_reg - CW'(pop);

  assign o_in_ready = (count_reg != CW'(DEPTH));
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign o_out_valid = valid_reg;
  assign o_out_data = data_reg[0];

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      valid_reg <= (count_next != '0);
    end
  end

  // Head always sits in entry 0 so the output comes straight from a flop
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (push && wr_idx == CW'(i)) begin
        data_reg[i] <= i_in_data;
      end else if (pop && i < DEPTH - 1) begin
        data_reg[i] <= data_reg[(i + 1) % DEPTH];
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/spd_host.sv
// Programmer end: reset sequencing, clock generation, instruction framing
`include "spd_defines.svh"
`default_nettype none
module spd_host #(
  parameter int WAIT_CYC = `SPD_WAIT_CYC,
  parameter int RST_PULSE_CYC = `SPD_RST_PULSE_XTAL,
  parameter int SCK_HALF_CYC = `SPD_SCK_HALF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  spd_if.host link,
  input wire logic i_cmd_valid,
  input wire logic [31:0] i_cmd_word,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_word,
  input wire logic i_rsp_ready,
  output logic o_synced
);
  localparam int CW = $clog2(WAIT_CYC + 1);
  localparam int DW = $clog2(SCK_HALF_CYC + 1);
  localparam spd_pkg::spd_instr_t ENABLE_WORD =
    {`SPD_OP_ENABLE, `SPD_SYNC_BYTE, `SPD_FILL_BYTE, `SPD_FILL_BYTE};

  spd_pkg::spd_host_state_e state_reg;
  logic [CW-1:0] cnt_reg;
  logic [DW-1:0] div_reg;
  logic [4:0] bit_reg;
  spd_pkg::spd_instr_t tx_reg;
  spd_pkg::spd_instr_t rx_reg;
  logic sck_reg;
  logic mosi_reg;
  logic rst_pin_reg;
  logic [1:0] miso_sync_reg;
  logic is_en_reg;
  logic synced_reg;
  logic cmd_ready_reg;
  logic buf_ready;

  wire half_done = (div_reg == DW'(SCK_HALF_CYC - 1));
  wire last_bit = (bit_reg == 5'h1f);
  wire frame_end = (state_reg == spd_pkg::HS_SHIFT) && half_done && sck_reg && last_bit;
  wire echo_ok = (rx_reg[15:8] == `SPD_SYNC_BYTE);
  wire cmd_take = (state_reg == spd_pkg::HS_IDLE) && cmd_ready_reg && i_cmd_valid;
  wire push_valid = (state_reg == spd_pkg::HS_PUSH);

  assign link.prog_rst_n = rst_pin_reg;
  assign link.sck = sck_reg;
  assign link.mosi = mosi_reg;
  assign o_cmd_ready = cmd_ready_reg;
  assign o_synced = synced_reg;

  // MISO is another domain's pin, so it is synchronised before sampling
  always_ff @(posedge i_sys_clk) begin
    miso_sync_reg <= {miso_sync_reg[0], link.miso};
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= spd_pkg::HS_PULSE;
      cnt_reg <= '0;
      div_reg <= '0;
      bit_reg <= 5'h0;
      tx_reg <= '0;
      rx_reg <= '0;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      rst_pin_reg <= 1'b0;
      is_en_reg <= 1'b0;
      synced_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end else begin
      case (state_reg)
        spd_pkg::HS_PULSE: begin
          sck_reg <= 1'b0;
          rst_pin_reg <= (cnt_reg != CW'(RST_PULSE_CYC));
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CW'(RST_PULSE_CYC)) begin
            cnt_reg <= '0;
            state_reg <= spd_pkg::HS_WAIT;
          end
        end
        spd_pkg::HS_WAIT: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CW'(WAIT_CYC - 1)) begin
            state_reg <= spd_pkg::HS_SHIFT;
            tx_reg <= ENABLE_WORD;
            mosi_reg <= ENABLE_WORD[31];
            bit_reg <= 5'h0;
            div_reg <= '0;
            is_en_reg <= 1'b1;
          end
        end
        spd_pkg::HS_SHIFT: begin
          div_reg <= half_done ? '0 : div_reg + 1'b1;
          if (half_done && !sck_reg) begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[30:0], miso_sync_reg[1]};
          end else if (half_done) begin
            sck_reg <= 1'b0;
            bit_reg <= bit_reg + 5'h1;
            tx_reg <= {tx_reg[30:0], 1'b0};
            mosi_reg <= tx_reg[30];
          end
          if (frame_end && is_en_reg && echo_ok) begin
            state_reg <= spd_pkg::HS_IDLE;
            synced_reg <= 1'b1;
            cmd_ready_reg <= 1'b1;
          end else if (frame_end && is_en_reg) begin
            state_reg <= spd_pkg::HS_PULSE;
            cnt_reg <= '0;
          end else if (frame_end) begin
            state_reg <= spd_pkg::HS_PUSH;
          end
        end
        spd_pkg::HS_PUSH: begin
          if (buf_ready) begin
            state_reg <= spd_pkg::HS_IDLE;
            cmd_ready_reg <= 1'b1;
          end
        end
        spd_pkg::HS_IDLE: begin
          if (cmd_take) begin
            cmd_ready_reg <= 1'b0;
            state_reg <= spd_pkg::HS_SHIFT;
            tx_reg <= i_cmd_word;
            mosi_reg <= i_cmd_word[31];
            bit_reg <= 5'h0;
            div_reg <= '0;
            is_en_reg <= 1'b0;
          end
        end
        default: state_reg <= spd_pkg::HS_PULSE;
      endcase
    end
  end

  // A full answer buffer holds the next instruction back
  spd_buf #(
    .WIDTH(32),
    .DEPTH(2)
  ) u_rsp_buf (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(push_valid),
    .i_in_data(rx_reg),
    .o_in_ready(buf_ready),
    .o_out_valid(o_rsp_valid),
    .o_out_data(o_rsp_word),
    .i_out_ready(i_rsp_ready)
  );
endmodule
`default_nettype wire

// File: rtl/spd_device.sv
// Device end: serial link shifter on the link clock, memories on the crystal clock
`include "spd_defines.svh"
`default_nettype none
module spd_device #(
  parameter int PROG_WORDS = `SPD_PROG_WORDS,
  parameter int EE_BYTES = `SPD_EE_BYTES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  spd_if.dev link,
  output logic o_prog_mode,
  output logic o_enabled,
  output logic o_commit
);
  localparam int PAW = $clog2(PROG_WORDS);
  localparam int EAW = $clog2(EE_BYTES);

  // Link clock domain, cleared while the reset pin is high
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [6:0] shift_reg;
  spd_pkg::spd_byte_t op_reg;
  spd_pkg::spd_byte_t ahi_reg;
  spd_pkg::spd_byte_t alo_reg;
  spd_pkg::spd_byte_t last_reg;
  spd_pkg::spd_byte_t out_reg;
  spd_pkg::spd_instr_t cmd_reg;
  logic link_en_reg;
  logic cmd_en_reg;
  logic cmd_tgl_reg;

  // Crystal clock domain
  logic [1:0] pin_sync_reg;
  logic [1:0] en_sync_reg;
  logic [1:0] tgl_sync_reg;
  logic tgl_seen_reg;
  logic prog_mode_reg;
  logic enabled_reg;
  logic commit_reg;
  logic [15:0] prog_mem [PROG_WORDS];
  logic [7:0] ee_mem [EE_BYTES];

  // Serial side decode
  wire byte_done = (bit_cnt_reg == 3'h7);
  wire [7:0] byte_in = {shift_reg, link.mosi};
  wire last_byte = (byte_cnt_reg == 2'h3);
  wire is_enable = (op_reg == `SPD_OP_ENABLE) && (ahi_reg == `SPD_SYNC_BYTE);
  wire [PAW-1:0] rd_paddr = PAW'({ahi_reg, alo_reg});
  wire [EAW-1:0] rd_eaddr = EAW'({ahi_reg, alo_reg});
  wire [15:0] rd_pword = prog_mem[rd_paddr];
  wire [7:0] rd_ebyte = ee_mem[rd_eaddr];
  wire op_rd_ph = (op_reg == `SPD_OP_RD_PH);
  wire op_rd_pl = (op_reg == `SPD_OP_RD_PL);
  wire op_rd_ee = (op_reg == `SPD_OP_RD_EE);
  wire rd_hit = link_en_reg && (op_rd_ph || op_rd_pl || op_rd_ee);
  wire [7:0] rd_byte = op_rd_ph ? rd_pword[15:8] :
                       op_rd_pl ? rd_pword[7:0] : rd_ebyte;
  wire load_out = (bit_cnt_reg == 3'h0);
  wire [7:0] resp_byte = (last_byte && rd_hit) ? rd_byte : last_reg;

  // Crystal side decode; the command word is held steady long after its toggle
  wire [7:0] c_op = cmd_reg[31:24];
  wire [PAW-1:0] c_paddr = PAW'(cmd_reg[23:8]);
  wire [EAW-1:0] c_eaddr = EAW'(cmd_reg[23:8]);
  wire [7:0] c_data = cmd_reg[7:0];
  wire cmd_arrive = (tgl_sync_reg[1] != tgl_seen_reg);
  wire exec = cmd_arrive && prog_mode_reg && cmd_en_reg;
  wire do_erase = exec && (c_op == `SPD_OP_ERASE);
  wire do_wr_ph = exec && (c_op == `SPD_OP_WR_PH);
  wire do_wr_pl = exec && (c_op == `SPD_OP_WR_PL);
  wire do_wr_ee = exec && (c_op == `SPD_OP_WR_EE);
  wire do_any = do_erase || do_wr_ph || do_wr_pl || do_wr_ee;

  assign link.miso = out_reg[7];
  assign link.miso_oe = prog_mode_reg;
  assign o_prog_mode = prog_mode_reg;
  assign o_enabled = enabled_reg;
  assign o_commit = commit_reg;

  // The reset pin is the frame signal: it clears link state without clock edges,
  // since the programmer holds the link clock still while pulsing it
  always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
    if (link.prog_rst_n) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg <= 7'h00;
      last_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_in[6:0];
      if (byte_done) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
        last_reg <= byte_in;
      end
    end
  end

  always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
    if (link.prog_rst_n) begin
      op_reg <= 8'h00;
      ahi_reg <= 8'h00;
      alo_reg <= 8'h00;
    end else if (byte_done) begin
      if (byte_cnt_reg == 2'h0) begin
        op_reg <= byte_in;
      end
      if (byte_cnt_reg == 2'h1) begin
        ahi_reg <= byte_in;
      end
      if (byte_cnt_reg == 2'h2) begin
        alo_reg <= byte_in;
      end
    end
  end

  // A finished instruction is held and announced by a toggle
  always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
    if (link.prog_rst_n) begin
      cmd_reg <= 32'h0000_0000;
      cmd_en_reg <= 1'b0;
      cmd_tgl_reg <= 1'b0;
      link_en_reg <= 1'b0;
    end else if (byte_done && last_byte) begin
      cmd_reg <= {op_reg, ahi_reg, alo_reg, byte_in};
      cmd_en_reg <= link_en_reg;
      cmd_tgl_reg <= ~cmd_tgl_reg;
      if (is_enable) begin
        link_en_reg <= 1'b1;
      end
    end
  end

  // Each byte returns the byte before it, so the sync byte comes back in byte
  // three; a read places memory data in byte four instead. Memory is read across
  // domains, safe because no write lands within an instruction's first three bytes
  always_ff @(negedge link.sck or posedge link.prog_rst_n) begin
    if (link.prog_rst_n) begin
      out_reg <= 8'h00;
    end else if (load_out) begin
      out_reg <= resp_byte;
    end else begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_sync_reg <= 2'h0;
      en_sync_reg <= 2'h0;
      tgl_sync_reg <= 2'h0;
      tgl_seen_reg <= 1'b0;
      prog_mode_reg <= 1'b0;
      enabled_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], ~link.prog_rst_n};
      en_sync_reg <= {en_sync_reg[0], link_en_reg};
      tgl_sync_reg <= {tgl_sync_reg[0], cmd_tgl_reg};
      tgl_seen_reg <= tgl_sync_reg[1];
      prog_mode_reg <= pin_sync_reg[1];
      enabled_reg <= en_sync_reg[1];
      commit_reg <= do_any;
    end
  end

  // Memory contents survive reset; only instructions change them
  always_ff @(posedge i_sys_clk) begin
    if (do_erase) begin
      for (int i = 0; i < PROG_WORDS; i++) begin
        prog_mem[i] <= {`SPD_ERASED_BYTE, `SPD_ERASED_BYTE};
      end
    end else if (do_wr_ph) begin
      prog_mem[c_paddr][15:8] <= c_data;
    end else if (do_wr_pl) begin
      prog_mem[c_paddr][7:0] <= c_data;
    end
  end

  // Data memory write replaces the whole byte, so no prior erase is needed
  always_ff @(posedge i_sys_clk) begin
    if (do_erase) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_mem[i] <= `SPD_ERASED_BYTE;
      end
    end else if (do_wr_ee) begin
      ee_mem[c_eaddr] <= c_data;
    end
  end
endmodule
`default_nettype wire

// File: verification/spd_link_props.sv
// Concurrent checks on the serial programming pins
`default_nettype none
module spd_link_props (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_prog_rst_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  logic sck_prev_reg;
  logic [4:0] rise_cnt_reg;
  logic [7:0] idle_reg;
  // Rises wrap at 32, so a quiet link must sit on a frame boundary
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sck_prev_reg <= 1'b0;
      rise_cnt_reg <= 5'h00;
      idle_reg <= 8'h00;
    end else begin
      sck_prev_reg <= i_sck;
      rise_cnt_reg <= i_prog_rst_n ? 5'h00 : rise_cnt_reg + {4'h0, i_sck & ~sck_prev_reg};
      idle_reg <= (i_sck != sck_prev_reg) ? 8'h00 : idle_reg + {7'h0, idle_reg != 8'hff};
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_sck_low_min: assert property ($fell(i_sck) |-> !i_sck [*3])
    else $error("sck low phase too short");
  a_sck_high_min: assert property ($rose(i_sck) |-> i_sck [*3])
    else $error("sck high phase too short");
  a_sck_idle_rst: assert property (i_prog_rst_n |-> !i_sck)
    else $error("sck moves while reset pin high");
  a_mosi_rise: assert property (i_sck |-> $stable(i_mosi))
    else $error("mosi changed while sck high");
  a_miso_fall: assert property ($changed(i_miso) |-> !i_sck)
    else $error("miso changed while sck high");
  a_oe_on: assert property ($fell(i_prog_rst_n) |-> ##[1:8] i_miso_oe)
    else $error("miso not driven in programming mode");
  a_oe_off: assert property ($rose(i_prog_rst_n) |-> ##[1:8] !i_miso_oe)
    else $error("miso still driven after reset pin high");
  a_frame_len: assert property ((idle_reg == 8'd40) |-> (rise_cnt_reg == 5'h00))
    else $error("frame not a multiple of 32 bits");
endmodule
`default_nettype wire

// File: verification/serial_program_download_port_tb_top.sv
// Self-checking bench joining programmer and device ends
`default_nettype none
module serial_program_download_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic [31:0] i_cmd_word = 32'h0;
  logic i_rsp_ready = 1'b0;
  logic o_cmd_ready, o_rsp_valid, o_synced, o_prog_mode, o_enabled, o_commit;
  logic [31:0] o_rsp_word;
  int n_fail = 0;
  int checked = 0;
  int n_commit = 0;
  int exp_commit = 0;
  int nbit = 0;
  logic hold = 1'b1;
  logic mon_sck_q = 1'b0;
  logic [31:0] rnd = 32'h9bf01a2d;
  logic [31:0] rdy_s = 32'h9bf01a2d;
  logic [31:0] sh_mosi, sh_miso;
  logic [15:0] pm [4096];
  logic [7:0] ee [512];
  logic [23:0] rsp_q [$];
  logic [55:0] wire_q [$] = '{{32'ha1530000, 24'ha15300}};
  logic [55:0] w;
  spd_if link_if ();
  spd_host #(.WAIT_CYC(200)) spd_host_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .link(link_if), .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_word(o_rsp_word),
    .i_rsp_ready(i_rsp_ready), .o_synced(o_synced));
  spd_device spd_device_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(link_if),
    .o_prog_mode(o_prog_mode), .o_enabled(o_enabled), .o_commit(o_commit));
  spd_link_props spd_link_props_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_prog_rst_n(link_if.prog_rst_n), .i_sck(link_if.sck), .i_mosi(link_if.mosi),
    .i_miso(link_if.miso), .i_miso_oe(link_if.miso_oe));
  initial forever #4 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic limit(input int i, input string what);
    if (i >= 20000) begin
      check(what, 32'h0, 32'h1);
      print_verdict();
    end
  endtask
  // Model is updated before the wait for cmd_ready; the design keeps instruction order
  task automatic send(input logic [31:0] c);
    logic [7:0] b4;
    int i;
    int pa;
    int ea;
    pa = int'(c[19:8]);
    ea = int'(c[16:8]);
    b4 = c[15:8];
    case (c[31:24])
      8'h10: b4 = pm[pa][15:8];
      8'h11: b4 = pm[pa][7:0];
      8'h30: b4 = ee[ea];
      8'h20: pm[pa][15:8] = c[7:0];
      8'h21: pm[pa][7:0] = c[7:0];
      8'h31: ee[ea] = c[7:0];
      8'ha2: begin
        foreach (pm[k]) pm[k] = 16'hffff;
        foreach (ee[k]) ee[k] = 8'hff;
      end
      default: ;
    endcase
    if (c[31:24] inside {8'h20, 8'h21, 8'h31, 8'ha2})
      exp_commit++;
    rsp_q.push_back({c[31:16], b4});
    wire_q.push_back({c, c[31:16], b4});
    for (i = 0; i < 20000 && o_cmd_ready !== 1'b1; i++) @(posedge i_sys_clk) #1;
    limit(i, "cmd_ready");
    i_cmd_valid = 1'b1;
    i_cmd_word = c;
    @(posedge i_sys_clk) #1;
    i_cmd_valid = 1'b0;
  endtask
  task automatic rd3(input logic [15:0] a);
    send({8'h10, a, 8'h00});
    send({8'h11, a, 8'h00});
    send({8'h30, a, 8'h00});
  endtask
  task automatic settle(input string what);
    int i;
    for (i = 0; i < 20000 && (n_commit != exp_commit || rsp_q.size() != 0 ||
         wire_q.size() != 0); i++) @(posedge i_sys_clk) #1;
    limit(i, what);
  endtask
  always @(posedge i_sys_clk) begin
    if (o_commit === 1'b1)
      n_commit++;
    if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1) begin
      if (rsp_q.size() == 0)
        check("rsp_extra", 32'h1, 32'h0);
      else
        check("rsp_word", {8'h0, o_rsp_word[23:0]}, {8'h0, rsp_q.pop_front()});
    end
    rdy_s <= lfsr(rdy_s);
    i_rsp_ready <= #1 !hold && rdy_s[0];
    // Host samples the link on sck rise, so the bench does the same
    mon_sck_q <= link_if.sck;
    if (link_if.prog_rst_n === 1'b1)
      nbit = 0;
    else if (link_if.sck === 1'b1 && mon_sck_q === 1'b0) begin
      sh_mosi = {sh_mosi[30:0], link_if.mosi};
      sh_miso = {sh_miso[30:0], link_if.miso};
      nbit++;
      if (nbit == 32) begin
        nbit = 0;
        w = (wire_q.size() != 0) ? wire_q.pop_front() : 56'h0;
        check("mosi_frame", sh_mosi, w[55:24]);
        check("miso_frame", {8'h0, sh_miso[23:0]}, {8'h0, w[23:0]});
      end
    end
  end
  initial begin
    int i;
    logic [15:0] a;
    logic [7:0] d;
    repeat (20) @(posedge i_sys_clk);
    #1 i_reset = 1'b0;
    hold = 1'b0;
    for (i = 0; i < 20000 && {o_synced, o_enabled} !== 2'b11; i++) @(posedge i_sys_clk) #1;
    limit(i, "sync");
    check("prog_mode", {31'h0, o_prog_mode}, 32'h1);
    $display("test sync done");
    send(32'ha2000000);
    settle("erase");
    rd3(16'h0000);
    rd3(16'h0fff);
    rd3(16'h01ff);
    $display("test erase done");
    for (int j = 0; j < 8; j++) begin
      rnd = lfsr(rnd);
      a = (j == 0) ? 16'h0fff : (j == 1) ? 16'h01ff : rnd[15:0];
      d = rnd[23:16];
      send({8'h20, a, d});
      send({8'h21, a, ~d});
      send({8'h31, a, d});
      send({8'h31, a, ~d ^ 8'h5a});
      rd3(a);
    end
    // Leftover answers would fill the buffer early and stall a read before the third
    settle("write");
    $display("test write done");
    hold = 1'b1;
    rd3(16'h0123);
    for (i = 0; i < 20000 && wire_q.size() != 0; i++) @(posedge i_sys_clk) #1;
    limit(i, "stall");
    repeat (20) @(posedge i_sys_clk);
    #1 check("stall_ready", {31'h0, o_cmd_ready}, 32'h0);
    hold = 1'b0;
    settle("drain");
    check("commits", 32'(n_commit), 32'(exp_commit));
    $display("test stall done");
    print_verdict();
  end
endmodule
`default_nettype wire
